// file: logic/channel_mode_enable_regs.sv
// Channel 3/4 mode register and channel enable/polarity register
`timescale 1ns/1ps
`include "channel_mode_enable_defs.svh"
// Operation
// RL1: Channel 4 direction decodes output, four, three, trigger
// RL2: Channel 3 direction decodes output, three, four, trigger
// RL3: Trigger mapping needs internal trigger source selected
// RL4: Channel 4 direction writable only while disabled
// RL5: Channel 3 direction writable only while disabled
// RL6: Upper mode byte holds channel 4 output controls
// RL7: Lower mode byte holds channel 3 output controls
// RL8: Input mode reads filter and capture divider fields
// RL9: Software keeps reserved top bits at reset
// RL10: Four-bit enable/polarity group per channel
// RL11: Complementary polarity zero high, one low
// RL12: Main polarity zero high, one low
// RL13: Input polarity pair selects edge and inversion
// RL14: No both-edges in encoder, never reserved code
// RL15: Complementary channel bits preloaded, commutation load
// RL16: Protect level two or three blocks polarity
// RL17: Complementary enable gates complementary output drive
// RL18: Main enable gates main output drive
// RL19: Compare mode field selects eight compare behaviours
// RL20: Capture divider ratio, cleared while disabled
// RL21: Input enable allows counter capture
// RL22: Shared bits follow channel direction field
// RL23: Registers reset zero, reserved bits read zero
module channel_mode_enable_regs (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic commutationEvent,
  input wire logic [3:0] outputRef,
  output channel_mode_enable_pkg::direction_t ch3DirectionSelect,
  output channel_mode_enable_pkg::direction_t ch4DirectionSelect,
  output logic [2:0] ch3InputRoute,
  output logic [2:0] ch4InputRoute,
  output channel_mode_enable_pkg::compare_mode_t ch3CompareMode,
  output channel_mode_enable_pkg::compare_mode_t ch4CompareMode,
  output logic [2:0] ch3CompareFlags,
  output logic [2:0] ch4CompareFlags,
  output logic [3:0] ch3InputFilter,
  output logic [3:0] ch4InputFilter,
  output logic [3:0] ch3CaptureRatio,
  output logic [3:0] ch4CaptureRatio,
  output logic [3:0] chEnable,
  output logic [3:0] chPolarity,
  output logic [2:0] chCompEnable,
  output logic [2:0] chCompPolarity,
  output logic [3:0] senseRising,
  output logic [3:0] senseFalling,
  output logic [3:0] inputInvert,
  output logic [3:0] captureEnable,
  output logic [3:0] dividerClear,
  output logic [3:0] mainOutLevel,
  output logic [3:0] mainOutDrive,
  output logic [2:0] compOutLevel,
  output logic [2:0] compOutDrive
);

  logic [15:0] modeReg_q; // Channel 3/4 mode register
  logic [15:0] enpolReg_q; // Software-visible enable/polarity copy
  logic [15:0] enpolAct_q; // Copy that steers the channels
  logic [15:0] auxReg_q; // Commutation control, protect level, dirs
  logic [7:0] awAddr_q; // Held write address
  logic awHeld_q; // Write address taken, waiting for data
  logic [31:0] wData_q; // Held write data
  logic [3:0] wStrb_q; // Held byte enables
  logic wHeld_q; // Write data taken, waiting for address
  channel_mode_enable_pkg::write_state_t wrState_q;
  logic [1:0] bResp_q;
  logic rValid_q;
  logic [31:0] rData_q;
  logic [1:0] rResp_q;
  logic doWrite; // Both halves present, no response pending
  logic comLoad; // Commutation from pin or software
  logic comSoft; // Software commutation request this cycle
  logic [15:0] wrMask; // Byte enables spread over 16 bits
  logic [15:0] modeD; // Mode register candidate value
  logic [15:0] enpolD; // Enable/polarity candidate value
  logic [1:0] lockLevel;
  logic lockPol; // Level 2 or 3 reached
  logic [3:0] chIsOutput; // Per-channel direction is output

  assign lockLevel = auxReg_q[`CME_AUX_LOCK_LO +: 2];
  assign lockPol = (lockLevel >= `CME_LOCK_POL);
  assign chIsOutput[0] = (auxReg_q[`CME_AUX_CH1_DIR_LO +: 2] == 2'h0);
  assign chIsOutput[1] = (auxReg_q[`CME_AUX_CH2_DIR_LO +: 2] == 2'h0);
  assign chIsOutput[2] = (modeReg_q[`CME_CH3_DIR_LO +: 2] == 2'h0);
  assign chIsOutput[3] = (modeReg_q[`CME_CH4_DIR_LO +: 2] == 2'h0);
  assign wrMask = {{8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
  assign doWrite = awHeld_q && wHeld_q &&
                   (wrState_q == channel_mode_enable_pkg::WR_IDLE);
  assign comSoft = doWrite && (awAddr_q == `CME_OFF_AUX) &&
                   wStrb_q[1] && wData_q[`CME_AUX_COM_EVENT];
  assign comLoad = commutationEvent || comSoft;

  // Handshake outputs straight from the holding state
  assign s_axi_awready = !awHeld_q;
  assign s_axi_wready = !wHeld_q;
  assign s_axi_bvalid = (wrState_q == channel_mode_enable_pkg::WR_RESP);
  assign s_axi_bresp = bResp_q;
  assign s_axi_arready = !rValid_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rResp_q;

  // Mode register candidate, with the guarded fields held back
  always_comb begin
    modeD = (modeReg_q & ~wrMask) | (wData_q[15:0] & wrMask);
    // Direction frozen while the channel is enabled
    if (enpolReg_q[12]) begin
      modeD[`CME_CH4_DIR_LO +: 2] = modeReg_q[`CME_CH4_DIR_LO +: 2]; // see RL4
    end
    if (enpolReg_q[8]) begin
      modeD[`CME_CH3_DIR_LO +: 2] = modeReg_q[`CME_CH3_DIR_LO +: 2]; // see RL5
    end
    // Top protect level freezes compare mode and preload on outputs
    if (lockLevel == 2'h3 && chIsOutput[3]) begin
      modeD[`CME_CH4_MODE_LO +: 3] = modeReg_q[`CME_CH4_MODE_LO +: 3];
      modeD[`CME_CH4_PRELOAD] = modeReg_q[`CME_CH4_PRELOAD];
    end
    if (lockLevel == 2'h3 && chIsOutput[2]) begin
      modeD[`CME_CH3_MODE_LO +: 3] = modeReg_q[`CME_CH3_MODE_LO +: 3];
      modeD[`CME_CH3_PRELOAD] = modeReg_q[`CME_CH3_PRELOAD];
    end
  end

  // Enable/polarity candidate, polarity bits guarded by protect level
  always_comb begin
    enpolD = (enpolReg_q & ~wrMask) | (wData_q[15:0] & wrMask);
    enpolD = enpolD & `CME_ENPOL_USED; // see RL23
    for (int c = 0; c < 4; c++) begin
      if (lockPol) begin
        enpolD[4 * c + 1] = enpolReg_q[4 * c + 1]; // see RL16
      end
      if (lockPol && chIsOutput[c] && c < 3) begin
        enpolD[4 * c + 3] = enpolReg_q[4 * c + 3]; // see RL16
      end
    end
  end

  // Write address channel; either half may arrive first
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      awHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
    end else if (clkEn) begin
      if (s_axi_awvalid && !awHeld_q) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_q <= 1'b0;
      end
    end
  end

  // Write data channel
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wHeld_q <= 1'b0;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
    end else if (clkEn) begin
      if (s_axi_wvalid && !wHeld_q) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld_q <= 1'b0;
      end
    end
  end

  // Write response; a new write waits until the old answer is taken
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wrState_q <= channel_mode_enable_pkg::WR_IDLE;
      bResp_q <= `CME_RESP_OKAY;
    end else if (clkEn) begin
      case (wrState_q)
        channel_mode_enable_pkg::WR_IDLE: begin
          if (doWrite) begin
            wrState_q <= channel_mode_enable_pkg::WR_RESP;
            case (awAddr_q)
              `CME_OFF_AUX, `CME_OFF_STATUS, `CME_OFF_MODE,
              `CME_OFF_ENPOL: bResp_q <= `CME_RESP_OKAY;
              default: bResp_q <= `CME_RESP_SLVERR;
            endcase
          end
        end
        channel_mode_enable_pkg::WR_RESP: begin
          if (s_axi_bready) begin
            wrState_q <= channel_mode_enable_pkg::WR_IDLE;
          end
        end
        default: wrState_q <= channel_mode_enable_pkg::WR_IDLE;
      endcase
    end
  end

  // Register stores; status is read-only and ignores writes
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      modeReg_q <= `CME_MODE_RESET; // see RL23
      enpolReg_q <= `CME_ENPOL_RESET; // see RL23
      auxReg_q <= `CME_AUX_RESET;
    end else if (clkEn && doWrite) begin
      case (awAddr_q)
        `CME_OFF_MODE: modeReg_q <= modeD;
        `CME_OFF_ENPOL: enpolReg_q <= enpolD;
        `CME_OFF_AUX: begin
          auxReg_q <= ((auxReg_q & ~wrMask) | (wData_q[15:0] & wrMask)) &
                      `CME_AUX_USED;
        end
        default: begin
          // Unmapped or read-only: nothing stored
        end
      endcase
    end
  end

  // Active enable/polarity copies, one group of four per channel
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gChan
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          enpolAct_q[4 * g +: 4] <= 4'h0;
        end else if (clkEn) begin
          // With commutation preload set, channels with a complementary output wait for commutation
          if (g < 3 && auxReg_q[`CME_AUX_COMMUTATION_PRELOAD_CONTROL]) begin
            if (comLoad) begin
              enpolAct_q[4 * g +: 4] <= enpolReg_q[4 * g +: 4]; // see RL15
            end
          end else begin
            enpolAct_q[4 * g +: 4] <= enpolReg_q[4 * g +: 4]; // see RL10
          end
        end
      end

      // Pin-facing levels; polarity inverts the reference
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          mainOutLevel[g] <= 1'b0;
          mainOutDrive[g] <= 1'b0;
        end else if (clkEn) begin
          mainOutLevel[g] <= outputRef[g] ^ enpolAct_q[4 * g + 1]; // see RL12
          mainOutDrive[g] <= enpolAct_q[4 * g] && chIsOutput[g]; // see RL18
        end
      end

      if (g < 3) begin : gComp
        always_ff @(posedge sys_clk or negedge reset_n) begin
          if (!reset_n) begin
            compOutLevel[g] <= 1'b0;
            compOutDrive[g] <= 1'b0;
          end else if (clkEn) begin
            // Complementary is the inverse of the reference
            compOutLevel[g] <= !outputRef[g] ^
              enpolAct_q[4 * g + 3]; // see RL11
            compOutDrive[g] <= enpolAct_q[4 * g + 2] &&
              chIsOutput[g]; // see RL17
          end
        end
        assign chCompEnable[g] = enpolAct_q[4 * g + 2];
        assign chCompPolarity[g] = enpolAct_q[4 * g + 3];
      end

      assign chEnable[g] = enpolAct_q[4 * g];
      assign chPolarity[g] = enpolAct_q[4 * g + 1];
      // Input sense: {comp, main} 00 rise, 01 fall inverted, 11 both
      assign senseRising[g] = !chIsOutput[g] &&
        (enpolAct_q[4 * g + 1] == enpolAct_q[4 * g + 3]); // see RL13
      assign senseFalling[g] = !chIsOutput[g] &&
        enpolAct_q[4 * g + 1]; // see RL13
      assign inputInvert[g] = !chIsOutput[g] && enpolAct_q[4 * g + 1] &&
        !enpolAct_q[4 * g + 3]; // see RL13
      assign captureEnable[g] = !chIsOutput[g] &&
        enpolAct_q[4 * g]; // see RL21
      assign dividerClear[g] = !enpolAct_q[4 * g]; // see RL20
    end
  endgenerate

  // Direction and input routing; route is {trigger, four, three}
  assign ch3DirectionSelect = channel_mode_enable_pkg::direction_t'(
    modeReg_q[`CME_CH3_DIR_LO +: 2]);
  assign ch4DirectionSelect = channel_mode_enable_pkg::direction_t'(
    modeReg_q[`CME_CH4_DIR_LO +: 2]);
  always_comb begin
    case (ch3DirectionSelect) // see RL2
      channel_mode_enable_pkg::DIR_INPUT_NATIVE: ch3InputRoute = 3'h1;
      channel_mode_enable_pkg::DIR_INPUT_CROSS: ch3InputRoute = 3'h2;
      channel_mode_enable_pkg::DIR_INPUT_TRIGGER: ch3InputRoute = 3'h4;
      default: ch3InputRoute = 3'h0; // Output: no input
    endcase
    case (ch4DirectionSelect) // see RL1
      channel_mode_enable_pkg::DIR_INPUT_NATIVE: ch4InputRoute = 3'h2;
      channel_mode_enable_pkg::DIR_INPUT_CROSS: ch4InputRoute = 3'h1;
      channel_mode_enable_pkg::DIR_INPUT_TRIGGER: ch4InputRoute = 3'h4;
      default: ch4InputRoute = 3'h0; // Output: no input
    endcase
  end

  // Shared bits read as compare or capture fields by direction
  always_comb begin
    ch3CompareMode = channel_mode_enable_pkg::CMP_FROZEN;
    ch4CompareMode = channel_mode_enable_pkg::CMP_FROZEN;
    ch3CompareFlags = 3'h0;
    ch4CompareFlags = 3'h0;
    ch3InputFilter = 4'h0;
    ch4InputFilter = 4'h0;
    ch3CaptureRatio = 4'h0;
    ch4CaptureRatio = 4'h0;
    if (chIsOutput[2]) begin // see RL22
      ch3CompareMode = channel_mode_enable_pkg::compare_mode_t'(
        modeReg_q[`CME_CH3_MODE_LO +: 3]); // see RL19
      ch3CompareFlags = {modeReg_q[`CME_CH3_CLEAR],
        modeReg_q[`CME_CH3_PRELOAD], modeReg_q[`CME_CH3_FAST]}; // see RL7
    end else begin
      ch3InputFilter = modeReg_q[`CME_CH3_FILT_LO +: 4]; // see RL8
      ch3CaptureRatio = 4'h1 << modeReg_q[`CME_CH3_DIV_LO +: 2]; // see RL20
    end
    if (chIsOutput[3]) begin // see RL22
      ch4CompareMode = channel_mode_enable_pkg::compare_mode_t'(
        modeReg_q[`CME_CH4_MODE_LO +: 3]); // see RL19
      ch4CompareFlags = {modeReg_q[`CME_CH4_CLEAR],
        modeReg_q[`CME_CH4_PRELOAD], modeReg_q[`CME_CH4_FAST]}; // see RL6
    end else begin
      ch4InputFilter = modeReg_q[`CME_CH4_FILT_LO +: 4]; // see RL8
      ch4CaptureRatio = 4'h1 << modeReg_q[`CME_CH4_DIV_LO +: 2]; // see RL20
    end
  end

  // Read channel; one answer at a time, data held until taken
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rValid_q <= 1'b0;
      rData_q <= 32'h00000000;
      rResp_q <= `CME_RESP_OKAY;
    end else if (clkEn) begin
      if (s_axi_arvalid && !rValid_q) begin
        rValid_q <= 1'b1;
        rResp_q <= `CME_RESP_OKAY;
        case (s_axi_araddr)
          `CME_OFF_MODE: rData_q <= {16'h0000, modeReg_q};
          `CME_OFF_ENPOL: rData_q <= {16'h0000, enpolReg_q}; // see RL23
          `CME_OFF_AUX: rData_q <= {16'h0000, auxReg_q};
          `CME_OFF_STATUS: rData_q <= {16'h0000, enpolAct_q};
          default: begin
            rData_q <= 32'h00000000;
            rResp_q <= `CME_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        rValid_q <= 1'b0;
      end
    end
  end

endmodule

// file: logic/channel_mode_enable_defs.svh
// Offsets, field positions, reset values for the channel mode/enable block
`ifndef CHANNEL_MODE_ENABLE_DEFS_SVH
`define CHANNEL_MODE_ENABLE_DEFS_SVH
`define CME_OFF_AUX 8'h04
`define CME_OFF_STATUS 8'h0C
`define CME_OFF_MODE 8'h1C
`define CME_OFF_ENPOL 8'h20
`define CME_MODE_RESET 16'h0000
`define CME_ENPOL_RESET 16'h0000
`define CME_AUX_RESET 16'h0000
`define CME_ENPOL_USED 16'h3FFF
`define CME_AUX_USED 16'h00FF
`define CME_AUX_COMMUTATION_PRELOAD_CONTROL 0
`define CME_AUX_LOCK_LO 1
`define CME_AUX_CH1_DIR_LO 3
`define CME_AUX_CH2_DIR_LO 5
`define CME_AUX_COM_EVENT 8
`define CME_CH4_CLEAR 15
`define CME_CH4_MODE_LO 12
`define CME_CH4_PRELOAD 11
`define CME_CH4_FAST 10
`define CME_CH4_DIR_LO 8
`define CME_CH3_CLEAR 7
`define CME_CH3_MODE_LO 4
`define CME_CH3_PRELOAD 3
`define CME_CH3_FAST 2
`define CME_CH3_DIR_LO 0
`define CME_CH4_FILT_LO 12
`define CME_CH4_DIV_LO 10
`define CME_CH3_FILT_LO 4
`define CME_CH3_DIV_LO 2
`define CME_LOCK_POL 2'h2
`define CME_RESP_OKAY 2'h0
`define CME_RESP_SLVERR 2'h2
`endif

// file: logic/channel_mode_enable_pkg.sv
// Types shared by the channel mode/enable block
package channel_mode_enable_pkg;
  typedef enum logic [1:0] {
    DIR_OUTPUT = 2'h0,
    DIR_INPUT_NATIVE = 2'h1,
    DIR_INPUT_CROSS = 2'h2,
    DIR_INPUT_TRIGGER = 2'h3
  } direction_t;
  typedef enum logic [2:0] {
    CMP_FROZEN = 3'h0,
    CMP_SET_ACTIVE = 3'h1,
    CMP_SET_INACTIVE = 3'h2,
    CMP_TOGGLE = 3'h3,
    CMP_FORCE_INACTIVE = 3'h4,
    CMP_FORCE_ACTIVE = 3'h5,
    CMP_PULSE_WIDTH_1 = 3'h6,
    CMP_PULSE_WIDTH_2 = 3'h7
  } compare_mode_t;
  typedef enum logic [1:0] {
    WR_IDLE = 2'h1,
    WR_RESP = 2'h2
  } write_state_t;
endpackage

// file: tb/channel_mode_enable_regs_sva.sv
// Assertion checker for the channel mode/enable register block
`timescale 1ns/1ps
module channel_mode_enable_regs_sva (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic commutationEvent,
  input wire logic [3:0] outputRef,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire channel_mode_enable_pkg::direction_t ch3DirectionSelect,
  input wire channel_mode_enable_pkg::direction_t ch4DirectionSelect,
  input wire logic [2:0] ch3InputRoute,
  input wire logic [2:0] ch4InputRoute,
  input wire channel_mode_enable_pkg::compare_mode_t ch3CompareMode,
  input wire logic [2:0] ch3CompareFlags,
  input wire logic [3:0] ch4InputFilter,
  input wire logic [3:0] ch4CaptureRatio,
  input wire logic [3:0] chEnable,
  input wire logic [3:0] chPolarity,
  input wire logic [2:0] chCompEnable,
  input wire logic [2:0] chCompPolarity,
  input wire logic [3:0] senseRising,
  input wire logic [3:0] senseFalling,
  input wire logic [3:0] inputInvert,
  input wire logic [3:0] captureEnable,
  input wire logic [3:0] dividerClear,
  input wire logic [3:0] mainOutLevel,
  input wire logic [3:0] mainOutDrive,
  input wire logic [2:0] compOutLevel,
  input wire logic [2:0] compOutDrive
);
  // Edges since reset; $past looks into reset before two have passed
  logic [1:0] upCount_q;
  // Channel is an input when its direction field is nonzero
  wire logic ch3In = (ch3DirectionSelect != 2'h0);
  wire logic ch4In = (ch4DirectionSelect != 2'h0);
  // Expected one-hot route {trigger, input four, input three}
  function automatic logic [2:0] rt(input logic [1:0] d, input logic [2:0] n);
    return (d == 2'h0) ? 3'h0 : (d == 2'h1) ? n :
      (d == 2'h2) ? (n ^ 3'h3) : 3'h4;
  endfunction
  // Saturating counter after reset release
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      upCount_q <= 2'h0;
    end else if (upCount_q != 2'h2) begin
      upCount_q <= upCount_q + 2'h1;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  property p_ch4Route;
    ch4InputRoute == rt(ch4DirectionSelect, 3'h2);
  endproperty
  a_ch4Route: assert property (p_ch4Route)
    else $error("ch4 route wrong");
  property p_ch3Route;
    ch3InputRoute == rt(ch3DirectionSelect, 3'h1);
  endproperty
  a_ch3Route: assert property (p_ch3Route)
    else $error("ch3 route wrong");
  property p_shared3;
    ch3In |-> ch3CompareMode == 3'h0 && ch3CompareFlags == 3'h0;
  endproperty
  a_shared3: assert property (p_shared3)
    else $error("ch3 compare live");
  property p_filt4;
    !ch4In |-> ch4InputFilter == 4'h0 && ch4CaptureRatio == 4'h0;
  endproperty
  a_filt4: assert property (p_filt4) else $error("ch4 filter live");
  property p_capEn; captureEnable[3:2] == (chEnable[3:2] & {ch4In, ch3In});
  endproperty
  a_capEn: assert property (p_capEn)
    else $error("capture enable wrong");
  property p_divClr; dividerClear == ~chEnable; endproperty
  a_divClr: assert property (p_divClr)
    else $error("divider clear wrong");
  property p_mainLvl; upCount_q == 2'h2 && $past(clkEn) |->
    mainOutLevel == $past(outputRef ^ chPolarity); endproperty
  a_mainLvl: assert property (p_mainLvl)
    else $error("main level wrong");
  property p_compLvl; upCount_q == 2'h2 && $past(clkEn) |->
    compOutLevel == $past(~outputRef[2:0] ^ chCompPolarity); endproperty
  a_compLvl: assert property (p_compLvl)
    else $error("comp level wrong");
  property p_mainDrv; upCount_q == 2'h2 && $past(clkEn) |->
    mainOutDrive[3:2] == $past(chEnable[3:2] & ~{ch4In, ch3In}); endproperty
  a_mainDrv: assert property (p_mainDrv)
    else $error("main drive wrong");
  property p_compDrv; upCount_q == 2'h2 && $past(clkEn) |->
    compOutDrive[2] == $past(chCompEnable[2] & ~ch3In); endproperty
  a_compDrv: assert property (p_compDrv)
    else $error("comp drive wrong");
  property p_sense; ch3In && !(chCompPolarity[2] && !chPolarity[2]) |->
    senseRising[2] == (chCompPolarity[2] | ~chPolarity[2]) &&
    senseFalling[2] == chPolarity[2] &&
    inputInvert[2] == (chPolarity[2] & ~chCompPolarity[2]); endproperty
  a_sense: assert property (p_sense)
    else $error("ch3 sense wrong");
  c_trig: cover property (ch3DirectionSelect == 2'h3);
  c_comm: cover property (commutationEvent);
  c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind channel_mode_enable_regs channel_mode_enable_regs_sva u_sva (.*);

// file: tb/channel_mode_enable_regs_tb_top.sv
// Self-checking bench for the channel mode/enable register block
`timescale 1ns/1ps
module channel_mode_enable_regs_tb_top;
  // Bench-driven inputs, valued at time zero
  logic sys_clk = 1'h0;
  logic reset_n = 1'h0;
  logic clkEn = 1'h1;
  logic commutationEvent = 1'h0;
  logic [3:0] outputRef = 4'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  // Design outputs
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  channel_mode_enable_pkg::direction_t ch3DirectionSelect, ch4DirectionSelect;
  channel_mode_enable_pkg::compare_mode_t ch3CompareMode, ch4CompareMode;
  logic [2:0] ch3InputRoute, ch4InputRoute, ch3CompareFlags, ch4CompareFlags;
  logic [3:0] ch3InputFilter, ch4InputFilter, ch3CaptureRatio, ch4CaptureRatio;
  logic [3:0] chEnable, chPolarity, senseRising, senseFalling, inputInvert;
  logic [3:0] captureEnable, dividerClear, mainOutLevel, mainOutDrive;
  logic [2:0] chCompEnable, chCompPolarity, compOutLevel, compOutDrive;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [15:0] v;
  channel_mode_enable_regs uut (.*);
  always #2.5 sys_clk = ~sys_clk;
  // Reference levels move every cycle so the output paths carry traffic
  always @(posedge sys_clk) outputRef <= 4'($urandom);
  // Watchdog: the run needs a few hundred cycles at most
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      $display("Error at %0t: run hung", $time);
      finish_test();
    end
  end
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Reset for 16 cycles; released at an edge
  task automatic do_reset();
    reset_n <= 1'h0;
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'h1;
  endtask
  // Write: handshakes sampled mid-cycle, released after the taking edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic [1:0] er);
    logic pa, pw, ta, tw, bt;
    pa = 1'h1;
    pw = 1'h1;
    bt = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= 32'(d);
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!bt) begin
      @(negedge sys_clk);
      ta = pa && s_axi_awready;
      tw = pw && s_axi_wready;
      bt = s_axi_bvalid;
      if (bt) check(32'(s_axi_bresp), 32'(er));
      @(posedge sys_clk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
  endtask
  // Read and compare data and response
  task automatic rdc(input logic [7:0] a, input logic [15:0] e,
                     input logic [1:0] er);
    logic pa, ta, bt;
    pa = 1'h1;
    bt = 1'h0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!bt) begin
      @(negedge sys_clk);
      ta = pa && s_axi_arready;
      bt = s_axi_rvalid;
      if (bt) check(s_axi_rdata, 32'(e));
      if (bt) check(32'(s_axi_rresp), 32'(er));
      @(posedge sys_clk);
      if (ta) s_axi_arvalid <= 1'h0;
      pa = pa && !ta;
    end
  endtask
  // Decoded outputs of one channel from its mode byte
  task automatic chk_ch(input logic [7:0] b, input logic [2:0] n,
    input logic [1:0] dir, input logic [2:0] r, input logic [2:0] cm,
    input logic [2:0] fl, input logic [3:0] fi, input logic [3:0] ra);
    logic o;
    o = (b[1:0] == 2'h0);
    check(32'(dir), 32'(b[1:0]));
    check(32'(r), 32'(o ? 3'h0 : b[1:0] == 2'h1 ? n :
      b[1:0] == 2'h2 ? n ^ 3'h3 : 3'h4));
    check(32'(cm), 32'(o ? b[6:4] : 3'h0));
    check(32'(fl), 32'(o ? {b[7], b[3], b[2]} : 3'h0));
    check(32'(fi), 32'(o ? 4'h0 : b[7:4]));
    check(32'(ra), 32'(o ? 4'h0 : 4'h1 << b[3:2]));
  endtask
  initial begin
    void'($urandom(32'hF9984C71));
    do_reset();
    rdc(8'h1C, 16'h0, 2'h0);
    rdc(8'h20, 16'h0, 2'h0);
    // Every direction and compare mode code on both channels
    for (int i = 0; i < 32; i++) begin
      v = {1'($urandom), i[4], i[1:0], 2'($urandom), i[3:2],
           1'($urandom), i[4:2], 2'($urandom), i[1:0]};
      wr(8'h1C, v, 2'h0);
      rdc(8'h1C, v, 2'h0);
      chk_ch(v[7:0], 3'h1, ch3DirectionSelect, ch3InputRoute, ch3CompareMode,
        ch3CompareFlags, ch3InputFilter, ch3CaptureRatio);
      chk_ch(v[15:8], 3'h2, ch4DirectionSelect, ch4InputRoute, ch4CompareMode,
        ch4CompareFlags, ch4InputFilter, ch4CaptureRatio);
    end
    // Direction frozen while the channel is enabled
    wr(8'h20, 16'h1100, 2'h0);
    wr(8'h1C, 16'h0101, 2'h0);
    rdc(8'h1C, v & 16'h0303, 2'h0);
    wr(8'h20, 16'h0000, 2'h0);
    wr(8'h1C, 16'h0101, 2'h0);
    rdc(8'h1C, 16'h0101, 2'h0);
    // Random enable/polarity groups; ch3 input sense never reserved
    for (int i = 0; i < 16; i++) begin
      v = 16'($urandom) & 16'h3FFF;
      if (v[11]) v[9] = 1'h1;
      wr(8'h20, v, 2'h0);
      rdc(8'h20, v, 2'h0);
      check(32'(chEnable), 32'({v[12], v[8], v[4], v[0]}));
      check(32'(chPolarity), 32'({v[13], v[9], v[5], v[1]}));
      check(32'(chCompEnable), 32'({v[10], v[6], v[2]}));
      check(32'(chCompPolarity), 32'({v[11], v[7], v[3]}));
    end
    // Protect levels two and three; ch3 input keeps comp polarity free
    for (int l = 2; l < 4; l++) begin
      wr(8'h20, 16'h0200, 2'h0);
      wr(8'h1C, 16'h0101, 2'h0);
      wr(8'h04, 16'(l << 1), 2'h0);
      wr(8'h20, 16'h3FFF, 2'h0);
      rdc(8'h20, 16'h1F55, 2'h0);
      do_reset();
      rdc(8'h04, 16'h0, 2'h0);
    end
    // Commutation preload: ch1..3 wait for the event, ch4 does not
    wr(8'h04, 16'h0001, 2'h0);
    wr(8'h20, 16'h1777, 2'h0);
    rdc(8'h0C, 16'h1000, 2'h0);
    // Enable low: the commutation pulse is ignored, copies frozen
    clkEn <= 1'h0;
    commutationEvent <= 1'h1;
    @(posedge sys_clk);
    clkEn <= 1'h1;
    commutationEvent <= 1'h0;
    rdc(8'h0C, 16'h1000, 2'h0);
    commutationEvent <= 1'h1;
    @(posedge sys_clk);
    commutationEvent <= 1'h0;
    rdc(8'h0C, 16'h1777, 2'h0);
    wr(8'h20, 16'h0000, 2'h0);
    rdc(8'h0C, 16'h0777, 2'h0);
    wr(8'h04, 16'h0101, 2'h0);
    rdc(8'h0C, 16'h0000, 2'h0);
    // Unmapped place answers with an error
    wr(8'h40, 16'hFFFF, 2'h2);
    rdc(8'h40, 16'h0, 2'h2);
    finish_test();
  end
endmodule
